/* testbench/raex_exec_assertions.sv */
// concurrent checks on the executor ports
`timescale 1ns/10ps
module raex_exec_chk
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [13:0] instr,
    input wire logic [12:0] stack_top_entry,
    input wire logic [12:0] pc,
    input wire logic [7:0]  file_wdata,
    input wire logic        file_we,
    input wire logic        stack_pop,
    input wire logic [7:0]  acc,
    input wire logic [7:0]  irq_control_reg,
    input wire logic        carry_flag,
    input wire logic        digit_carry_flag,
    input wire logic        zero_flag,
    input wire logic        fetch_strobe
);
    // ****
    // assertions
    // ****
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_pop_loads_pc:
    assert property (stack_pop |-> pc == $past(stack_top_entry))
        else $error("pc not loaded from stack top");
    a_pop_keeps_flags:
    assert property (stack_pop |->
        $stable({carry_flag, digit_carry_flag, zero_flag}))
        else $error("flags changed by a return op");
    a_pop_then_fetch:
    assert property (stack_pop |-> (!fetch_strobe) [*4] ##1 fetch_strobe)
        else $error("second cycle of return op wrong");
    a_pc_holds_idle:
    assert property (stack_pop |=> $stable(pc) [*4])
        else $error("pc moved in second cycle");
    a_irq_low_bits:
    assert property (irq_control_reg[6:0] == 7'h00)
        else $error("irq control low bits set");
    a_gie_from_exit:
    assert property ($rose(irq_control_reg[7]) |->
        $past(instr, 3) == 14'h0009 ##1 stack_pop)
        else $error("enable bit set at wrong time");
    a_we_zero_match:
    assert property (file_we |-> zero_flag == (file_wdata == 8'h00))
        else $error("zero flag disagrees with result");
    a_lit_to_acc:
    assert property (stack_pop && $past(instr[13:10], 4) == 4'hD |->
        acc == $past(instr[7:0], 4))
        else $error("literal not in accumulator");
    cover property (stack_pop);
    cover property (file_we);
    cover property ($rose(irq_control_reg[7]));
endmodule : raex_exec_chk

/* testbench/raex_mem_model.sv */
// return stack and file register model
`timescale 1ns/10ps
module raex_mem_model
(
    input  wire logic        clock,
    input  wire logic        stack_pop,
    input  wire logic [6:0]  file_addr,
    input  wire logic [7:0]  file_wdata,
    input  wire logic        file_we,
    output logic      [12:0] stack_top_entry,
    output logic      [7:0]  file_rdata
);
    // ****
    // storage
    // ****
    logic [12:0] stk [0:7];
    logic [7:0]  mem [0:127];
    int          sp = 0;
    assign stack_top_entry = stk[sp];
    assign file_rdata = mem[file_addr];
    task push(input logic [12:0] v);
        sp = sp + 1;
        stk[sp] = v;
    endtask : push
    always @(posedge clock)
    begin
        if (stack_pop)
            sp <= sp - 1;
        if (file_we)
            mem[file_addr] <= file_wdata;
    end
endmodule : raex_mem_model

/* testbench/tb_return_and_logic_op_exec.sv */
// self-checking bench for the return and logic op executor
`timescale 1ns/10ps
module tb_return_and_logic_op_exec;
    // ****
    // harness
    // ****
    logic        clock;
    logic        rst;
    logic [13:0] instr;
    logic [12:0] stack_top_entry;
    logic [7:0]  file_rdata;
    logic [12:0] pc;
    logic [6:0]  file_addr;
    logic [7:0]  file_wdata;
    logic        file_we;
    logic        stack_pop;
    logic [7:0]  acc;
    logic [7:0]  irq_control_reg;
    logic        carry_flag;
    logic        digit_carry_flag;
    logic        zero_flag;
    logic        fetch_strobe;
    logic        illegal_op;
    int          failures = 0;
    int          checked = 0;
    int          cycles = 0;
    raex_exec uut (.*);
    raex_mem_model mdl (.*);
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // run needs about 53 cycles
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 400)
        begin
            failures++;
            stop_test();
        end
    end
    task stop_test();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // op held for all its cycles; the design samples it once
    task run(input logic [13:0] op, input int n);
        instr = op;
        repeat (4 * n) @(posedge clock);
        #2;
    endtask : run
    task st(input logic [12:0] p, input logic [7:0] a, input logic [2:0] f);
        chk(16'(pc), 16'(p));
        chk(16'(acc), 16'(a));
        chk(16'({carry_flag, digit_carry_flag, zero_flag}), 16'(f));
        chk(16'(fetch_strobe), 16'h0001);
    endtask : st
    // ****
    // tests
    // ****
    initial
    begin
        rst = 1'b1;
        instr = 14'h0000;
        mdl.push(13'h0040);
        mdl.push(13'h0ABC);
        mdl.push(13'h0123);
        mdl.mem[7'h10] = 8'h5B;
        mdl.mem[7'h11] = 8'h3C;
        repeat (5) @(posedge clock);
        #2;
        rst = 1'b0;
        run(14'h0060, 1);
        st(13'h0001, 8'h00, 3'h0);
        chk(16'(illegal_op), 16'h0000);
        run(14'h0100, 1);
        st(13'h0002, 8'h00, 3'h0);
        chk(16'(illegal_op), 16'h0001);
        run(14'h34A5, 2);
        st(13'h0123, 8'hA5, 3'h0);
        chk(16'(illegal_op), 16'h0000);
        run(14'h0790, 1);
        st(13'h0124, 8'hA5, 3'h7);
        run(14'h0511, 1);
        st(13'h0125, 8'h24, 3'h6);
        run(14'h0591, 1);
        chk(16'(mdl.mem[7'h10]), 16'h0000);
        st(13'h0126, 8'h24, 3'h6);
        run(14'h0008, 2);
        chk(16'(mdl.mem[7'h11]), 16'h0024);
        st(13'h0ABC, 8'h24, 3'h6);
        run(14'h0009, 2);
        st(13'h0040, 8'h24, 3'h6);
        chk(16'(irq_control_reg), 16'h0080);
        run(14'h0711, 1);
        st(13'h0041, 8'h48, 3'h0);
        chk(16'(mdl.mem[7'h11]), 16'h0024);
        stop_test();
    end
endmodule : tb_return_and_logic_op_exec
bind raex_exec raex_exec_chk chk_i (.*);

/* verilog/raex_alu.sv */
// file-register alu for and / add with flag outputs
`timescale 1ns/10ps
module raex_alu
(
    input  wire logic       is_add,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] file_val,
    output logic      [7:0] result,
    output logic            carry,
    output logic            digit_carry,
    output logic            zero
);
    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb
    begin
        sum     = {1'b0, acc} + {1'b0, file_val};
        low_sum = {1'b0, acc[3:0]} + {1'b0, file_val[3:0]};
        result  = is_add ? sum[7:0] : (acc & file_val);
        carry       = sum[8];
        digit_carry = low_sum[4];
        zero        = (result == 8'h00);
    end
endmodule : raex_alu

/* verilog/raex_cfg.svh */
// constants for the return and logic op executor
`ifndef RAEX_CFG_SVH
`define RAEX_CFG_SVH
`define RAEX_GIE_BIT        7
`define RAEX_PC_RESET       13'h0000
`define RAEX_ACC_RESET      8'h00
`define RAEX_IRQ_CTL_RESET  8'h00
`define RAEX_OP_IDLE        14'h0000
`define RAEX_OP_IDLE_MASK   14'h3F9F
`define RAEX_OP_RETURN      14'h0008
`define RAEX_OP_INT_EXIT    14'h0009
`define RAEX_OP_LIT_EXIT    4'hD
`define RAEX_OP_AND_FILE    6'h05
`define RAEX_OP_ADD_FILE    6'h07
`define RAEX_DEST_BIT       7
`endif

/* verilog/raex_exec.sv */
// decode and execute of return, and, add and idle ops
`timescale 1ns/10ps
`include "raex_cfg.svh"

module raex_exec
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [13:0] instr,
    input  wire logic [12:0] stack_top_entry,
    input  wire logic [7:0]  file_rdata,
    output logic      [12:0] pc,
    output logic      [6:0]  file_addr,
    output logic      [7:0]  file_wdata,
    output logic             file_we,
    output logic             stack_pop,
    output logic      [7:0]  acc,
    output logic      [7:0]  irq_control_reg,
    output logic             carry_flag,
    output logic             digit_carry_flag,
    output logic             zero_flag,
    output logic             fetch_strobe,
    output logic             illegal_op
);
    // ************************************************************
    // state
    // ************************************************************
    // one word of state; next_st is rebuilt from it every clock
    typedef struct packed {
        raex_pkg::raex_phase_t phase;
        raex_pkg::raex_kind_t  kind;
        logic                  second;
        logic [13:0]           op;
        logic [12:0]           pc;
        logic [7:0]            acc;
        logic [7:0]            irq_ctl;
        logic                  c;
        logic                  dc;
        logic                  z;
        logic [7:0]            wdata;
        logic                  we;
        logic                  pop;
        logic                  fetch;
        logic                  bad;
    } raex_state_t;

    raex_state_t st;
    raex_state_t next_st;

    logic [7:0] alu_result;
    logic       alu_c;
    logic       alu_dc;
    logic       alu_z;

    logic                 alu_is_add;
    raex_pkg::raex_kind_t dec_kind;
    logic                 dec_bad;

    raex_alu u_alu
    (
        .is_add      (alu_is_add),
        .acc         (st.acc),
        .file_val    (file_rdata),
        .result      (alu_result),
        .carry       (alu_c),
        .digit_carry (alu_dc),
        .zero        (alu_z)
    );

    // ************************************************************
    // decode
    // ************************************************************
    // no trap for unknown words: the host must watch illegal_op
    function automatic raex_pkg::raex_kind_t raex_decode
    (
        input logic [13:0] op
    );
        raex_pkg::raex_kind_t k;
        k = raex_pkg::RAEX_K_IDLE;
        if (op == `RAEX_OP_INT_EXIT)
            k = raex_pkg::RAEX_K_INTX;
        else if (op == `RAEX_OP_RETURN)
            k = raex_pkg::RAEX_K_RET;
        else if (op[13:10] == `RAEX_OP_LIT_EXIT)
            k = raex_pkg::RAEX_K_LITX;
        else if (op[13:8] == `RAEX_OP_AND_FILE)
            k = raex_pkg::RAEX_K_AND;
        else if (op[13:8] == `RAEX_OP_ADD_FILE)
            k = raex_pkg::RAEX_K_ADD;
        return k;
    endfunction : raex_decode

    // decoded every clock; only q1 of a first cycle keeps the result
    assign dec_kind   = raex_decode(instr);
    assign dec_bad    = (dec_kind == raex_pkg::RAEX_K_IDLE) &&
                        ((instr & `RAEX_OP_IDLE_MASK) != `RAEX_OP_IDLE);
    assign alu_is_add = (st.kind == raex_pkg::RAEX_K_ADD);

    // ************************************************************
    // quarter-cycle sequencer
    // ************************************************************
    always_comb
    begin
        next_st       = st;
        next_st.we    = 1'b0;
        next_st.pop   = 1'b0;
        next_st.fetch = 1'b0;
        case (st.phase)
            raex_pkg::RAEX_Q1:
            begin
                next_st.phase = raex_pkg::RAEX_Q2;
                if (!st.second)
                begin
                    // latch the word once; it may change mid-cycle
                    next_st.op   = instr;
                    next_st.kind = dec_kind;
                    // unknown words run as idle_op but stay flagged
                    next_st.bad  = dec_bad;
                end
            end
            raex_pkg::RAEX_Q2:
                next_st.phase = raex_pkg::RAEX_Q3;
            raex_pkg::RAEX_Q3:
            begin
                next_st.phase = raex_pkg::RAEX_Q4;
                if (!st.second && st.kind == raex_pkg::RAEX_K_INTX)
                    next_st.irq_ctl[`RAEX_GIE_BIT] = 1'b1;
            end
            raex_pkg::RAEX_Q4:
            begin
                next_st.phase = raex_pkg::RAEX_Q1;
                next_st.fetch = 1'b1;
                next_st.pc    = st.pc + 13'h0001;
                next_st.second = 1'b0;
                if (!st.second)
                begin
                    case (st.kind)
                        raex_pkg::RAEX_K_AND,
                        raex_pkg::RAEX_K_ADD:
                        begin
                            if (st.op[`RAEX_DEST_BIT])
                            begin
                                next_st.we    = 1'b1;
                                next_st.wdata = alu_result;
                            end
                            else
                                next_st.acc = alu_result;
                            next_st.z = alu_z;
                            // and keeps c and dc; only add rewrites them
                            if (st.kind == raex_pkg::RAEX_K_ADD)
                            begin
                                next_st.c  = alu_c;
                                next_st.dc = alu_dc;
                            end
                        end
                        raex_pkg::RAEX_K_RET,
                        raex_pkg::RAEX_K_INTX,
                        raex_pkg::RAEX_K_LITX:
                        begin
                            // returns leave c, dc and z alone
                            next_st.pc     = stack_top_entry;
                            next_st.pop    = 1'b1;
                            next_st.second = 1'b1;
                            next_st.fetch  = 1'b0;
                            if (st.kind == raex_pkg::RAEX_K_LITX)
                                next_st.acc = st.op[7:0];
                        end
                        default:
                            next_st.pc = st.pc + 13'h0001;
                    endcase
                end
                else
                    // second cycle is idle; pc already holds return
                    next_st.pc = st.pc;
            end
            default:
                next_st.phase = raex_pkg::RAEX_Q1;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            // reset loads q1, so instr is taken on the first edge after release
            st         <= '0;
            st.phase   <= raex_pkg::RAEX_Q1;
            st.kind    <= raex_pkg::RAEX_K_IDLE;
            st.pc      <= `RAEX_PC_RESET;
            st.acc     <= `RAEX_ACC_RESET;
            st.irq_ctl <= `RAEX_IRQ_CTL_RESET;
        end
        else
            st <= next_st;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign pc               = st.pc;
    assign file_addr        = st.op[6:0];
    assign file_wdata       = st.wdata;
    assign file_we          = st.we;
    assign stack_pop        = st.pop;
    assign acc              = st.acc;
    assign irq_control_reg  = st.irq_ctl;
    assign carry_flag       = st.c;
    assign digit_carry_flag = st.dc;
    assign zero_flag        = st.z;
    // we, pop and fetch stand for the single q1 after a q4
    assign fetch_strobe     = st.fetch;
    assign illegal_op       = st.bad;
endmodule : raex_exec

/* verilog/raex_pkg.sv */
// types for the return and logic op executor
package raex_pkg;
    typedef enum logic [3:0] {
        RAEX_Q1 = 4'h1,
        RAEX_Q2 = 4'h2,
        RAEX_Q3 = 4'h4,
        RAEX_Q4 = 4'h8
    } raex_phase_t;

    typedef enum logic [5:0] {
        RAEX_K_IDLE   = 6'h01,
        RAEX_K_AND    = 6'h02,
        RAEX_K_ADD    = 6'h04,
        RAEX_K_RET    = 6'h08,
        RAEX_K_INTX   = 6'h10,
        RAEX_K_LITX   = 6'h20
    } raex_kind_t;
endpackage : raex_pkg
